//--- src/bil_boot_image_loader.sv
// Reset exit, PLL strap decode and boot image loading for one processor tile.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "bil_defs.svh"

module bil_boot_image_loader #(
  parameter int DELAY_CYC = `BIL_BOOT_DELAY_CYC,
  parameter int ADDR_W = 16,
  parameter int GPIO_W = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Strap pins
  input wire logic i_pll_strap_bit0,
  input wire logic i_pll_strap_bit1,
  // Security word from OTP
  output logic o_sec_rd,
  input wire logic i_sec_valid,
  input wire logic [31:0] i_sec_data,
  // Boot byte source request
  output logic o_src_otp,
  output logic o_src_req,
  output logic [ADDR_W-1:0] o_src_addr,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  // PLL configuration write port
  input wire logic i_pll_wr,
  input wire bil_pkg::bil_pll_cfg_t i_pll_wdata,
  output bil_pkg::bil_pll_cfg_t o_pll_cfg,
  // RAM write port
  output bil_pkg::bil_ram_wr_t o_ram_wr,
  // Status
  output logic [GPIO_W-1:0] o_gpio_pulldown,
  output logic o_run,
  output logic [ADDR_W-1:0] o_start_addr,
  output logic o_boot_error,
  output logic o_crc_skipped
);

  // --------------------------------------------------------------------------
  // Strap synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  always_ff @(posedge i_clk) begin
    strap_meta <= {i_pll_strap_bit1, i_pll_strap_bit0};
    strap_sync <= strap_meta;
  end

  // --------------------------------------------------------------------------
  // State and counters
  // --------------------------------------------------------------------------
  bil_pkg::bil_state_t state;
  bil_pkg::bil_state_t next_state;
  logic [31:0] delay_cnt;
  logic [1:0] byte_idx;
  logic [31:0] word_acc;
  logic [31:0] prog_len;
  logic [31:0] words_done;
  logic [31:0] crc;
  logic [31:0] trailer;
  logic secure_boot;
  logic pll_loaded;

  logic [31:0] next_word;
  logic word_done;
  assign next_word = {i_byte, word_acc[31:8]};
  assign word_done = i_byte_valid && (byte_idx == 2'h3);

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `BIL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    next_state = state;
    unique case (state)
      bil_pkg::BIL_RESET: next_state = bil_pkg::BIL_SEC_LOAD;
      bil_pkg::BIL_SEC_LOAD: if (i_sec_valid) begin
        next_state = bil_pkg::BIL_DELAY;
      end
      bil_pkg::BIL_DELAY: if (delay_cnt >= 32'(DELAY_CYC - 1)) begin
        next_state = bil_pkg::BIL_LEN;
      end
      bil_pkg::BIL_LEN: if (word_done) begin
        next_state = (next_word == 32'h0) ? bil_pkg::BIL_TRAILER : bil_pkg::BIL_PROG;
      end
      bil_pkg::BIL_PROG: if (word_done && (words_done + 32'h1 == prog_len)) begin
        next_state = bil_pkg::BIL_TRAILER;
      end
      bil_pkg::BIL_TRAILER: if (word_done) begin
        next_state = bil_pkg::BIL_CHECK;
      end
      bil_pkg::BIL_CHECK: begin
        if (trailer == `BIL_NO_CRC_MAGIC || trailer == ~crc) begin
          next_state = bil_pkg::BIL_RUN;
        end else begin
          next_state = bil_pkg::BIL_ERROR;
        end
      end
      bil_pkg::BIL_RUN: next_state = bil_pkg::BIL_RUN;
      bil_pkg::BIL_ERROR: next_state = bil_pkg::BIL_ERROR;
      default: next_state = bil_pkg::BIL_RESET;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= bil_pkg::BIL_RESET;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Security word capture and boot delay
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      secure_boot <= 1'b0;
    end else if (state == bil_pkg::BIL_SEC_LOAD && i_sec_valid) begin
      secure_boot <= i_sec_data[`BIL_SECURE_BOOT_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || state != bil_pkg::BIL_DELAY) begin
      delay_cnt <= 32'h0;
    end else begin
      delay_cnt <= delay_cnt + 32'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Byte assembly, length, trailer and CRC
  // --------------------------------------------------------------------------
  logic loading;
  assign loading = (state == bil_pkg::BIL_LEN) || (state == bil_pkg::BIL_PROG) ||
                   (state == bil_pkg::BIL_TRAILER);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      byte_idx <= 2'h0;
      word_acc <= 32'h0;
    end else if (loading && i_byte_valid) begin
      byte_idx <= byte_idx + 2'h1;
      word_acc <= next_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      crc <= `BIL_CRC_PRESET;
    end else if ((state == bil_pkg::BIL_LEN || state == bil_pkg::BIL_PROG) && i_byte_valid) begin
      crc <= crc_byte(crc, i_byte);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prog_len <= 32'h0;
    end else if (word_done && state == bil_pkg::BIL_LEN) begin
      prog_len <= next_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      trailer <= 32'h0;
    end else if (word_done && state == bil_pkg::BIL_TRAILER) begin
      trailer <= next_word;
    end
  end

  // --------------------------------------------------------------------------
  // RAM writes from the lowest address
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      words_done <= 32'h0;
    end else if (word_done && state == bil_pkg::BIL_PROG) begin
      words_done <= words_done + 32'h1;
    end
  end

  // The write strobe drops back every cycle, so one assembled word makes one
  // RAM write however slowly the source paces its bytes.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_ram_wr <= '0;
    end else begin
      o_ram_wr.valid <= 1'b0;
      if (word_done && state == bil_pkg::BIL_PROG) begin
        o_ram_wr.valid <= 1'b1;
        o_ram_wr.addr <= 16'(`BIL_RAM_BASE + words_done[15:0]);
        o_ram_wr.data <= next_word;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Source requests
  // --------------------------------------------------------------------------
  // The source streams bytes while o_src_req is high; the address is the OTP
  // start word for secure boot and zero for flash.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_sec_rd <= 1'b0;
    end else begin
      o_sec_rd <= (next_state == bil_pkg::BIL_SEC_LOAD);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_src_otp <= 1'b0;
    end else begin
      o_src_otp <= secure_boot;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_src_req <= 1'b0;
    end else begin
      o_src_req <= (next_state == bil_pkg::BIL_LEN) || (next_state == bil_pkg::BIL_PROG) ||
                   (next_state == bil_pkg::BIL_TRAILER);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_src_addr <= '0;
    end else begin
      o_src_addr <= secure_boot ? ADDR_W'(`BIL_OTP_BASE) : '0;
    end
  end

  // --------------------------------------------------------------------------
  // PLL configuration
  // --------------------------------------------------------------------------
  bil_pkg::bil_pll_cfg_t strap_cfg;
  always_comb begin
    strap_cfg.ref_div = `BIL_PLL_REF_RST;
    strap_cfg.pll_output_divider = `BIL_PLL_OD_RST;
    strap_cfg.feedback = `BIL_PLL_FB_00;
    unique case (strap_sync)
      2'b00: strap_cfg.feedback = `BIL_PLL_FB_00;
      2'b11: strap_cfg.feedback = `BIL_PLL_FB_11;
      2'b10: strap_cfg.feedback = `BIL_PLL_FB_10;
      2'b01: strap_cfg.feedback = `BIL_PLL_FB_01;
    endcase
  end

  // Straps are sampled once the synchroniser has settled; a write after that
  // overrides them until the next reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pll_loaded <= 1'b0;
    end else if (state == bil_pkg::BIL_SEC_LOAD) begin
      pll_loaded <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pll_cfg <= '0;
    end else if (i_pll_wr && pll_loaded) begin
      o_pll_cfg <= i_pll_wdata;
    end else if (!pll_loaded && state == bil_pkg::BIL_SEC_LOAD) begin
      o_pll_cfg <= strap_cfg;
    end
  end

  // --------------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_gpio_pulldown <= '1;
    end else begin
      o_gpio_pulldown <= '0;
    end
  end

  // The outcome flags are decided once, in the check state, and then held
  // until the next reset, so a rejected image can never start later on.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_run <= 1'b0;
    end else if (state == bil_pkg::BIL_CHECK) begin
      o_run <= (next_state == bil_pkg::BIL_RUN);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_start_addr <= '0;
    end else if (state == bil_pkg::BIL_CHECK) begin
      o_start_addr <= ADDR_W'(`BIL_RAM_BASE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_boot_error <= 1'b0;
    end else if (state == bil_pkg::BIL_CHECK) begin
      o_boot_error <= (next_state == bil_pkg::BIL_ERROR);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_crc_skipped <= 1'b0;
    end else if (state == bil_pkg::BIL_CHECK) begin
      o_crc_skipped <= (trailer == `BIL_NO_CRC_MAGIC);
    end
  end

endmodule

//--- src/bil_defs.svh
// Offsets, field positions, reset values and timing counts of the boot image loader.
`ifndef BIL_DEFS_SVH
`define BIL_DEFS_SVH
// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define BIL_CLK_MHZ 200
`define BIL_BOOT_DELAY_MIN_US 15
`define BIL_BOOT_DELAY_MAX_US 150
// The minimum delay, rounded up to whole cycles.
`define BIL_BOOT_DELAY_CYC (`BIL_BOOT_DELAY_MIN_US * `BIL_CLK_MHZ)
// --------------------------------------------------------------------------
// Boot image
// --------------------------------------------------------------------------
`define BIL_NO_CRC_MAGIC 32'h0d15ab1e
`define BIL_CRC_POLY 32'hedb88320
`define BIL_CRC_PRESET 32'hffffffff
`define BIL_SECURE_BOOT_BIT 5
`define BIL_RAM_BASE 16'h0000
`define BIL_OTP_BASE 16'h0000
// --------------------------------------------------------------------------
// PLL settings selected by the straps
// --------------------------------------------------------------------------
`define BIL_PLL_FB_00 12'h09f
`define BIL_PLL_FB_11 12'h03f
`define BIL_PLL_FB_10 12'h01f
`define BIL_PLL_FB_01 12'h00f
`define BIL_PLL_OD_RST 3'h1
`define BIL_PLL_REF_RST 6'h00
`endif

//--- src/bil_pkg.sv
// Types shared by the boot image loader.
package bil_pkg;
  typedef struct packed {
    logic [5:0] ref_div;
    logic [11:0] feedback;
    logic [2:0] pll_output_divider;
  } bil_pll_cfg_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [31:0] data;
  } bil_ram_wr_t;

  typedef enum logic [3:0] {
    BIL_RESET, BIL_SEC_LOAD, BIL_DELAY, BIL_LEN, BIL_PROG, BIL_TRAILER,
    BIL_CHECK, BIL_RUN, BIL_ERROR
  } bil_state_t;
endpackage

//--- verification/bil_boot_image_loader_bench.sv
// Self-checking bench for the boot image loader.
`timescale 1ns/10ps
module bil_boot_image_loader_bench;
  logic i_clk, i_rst_b, s0, s1, pll_wr, slow, sec_rd, sec_v, otp, req, bval;
  logic run, berr, skip;
  logic [31:0] sec_d, pd;
  logic [15:0] saddr, start;
  logic [7:0] bdat;
  bil_pkg::bil_pll_cfg_t wdata, cfg;
  bil_pkg::bil_ram_wr_t ram;
  int err_total = 0;
  int checked = 0;
  int nwr;
  bil_boot_image_loader #(.DELAY_CYC(10)) bil_boot_image_loader_i (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_pll_strap_bit0(s0), .i_pll_strap_bit1(s1), .o_sec_rd(sec_rd),
    .i_sec_valid(sec_v), .i_sec_data(sec_d), .o_src_otp(otp), .o_src_req(req),
    .o_src_addr(saddr), .i_byte_valid(bval), .i_byte(bdat), .i_pll_wr(pll_wr),
    .i_pll_wdata(wdata), .o_pll_cfg(cfg), .o_ram_wr(ram), .o_gpio_pulldown(pd),
    .o_run(run), .o_start_addr(start), .o_boot_error(berr), .o_crc_skipped(skip));
  bil_boot_mem bil_boot_mem_i (.i_clk(i_clk), .i_slow(slow), .i_sec_rd(sec_rd),
    .i_src_req(req), .o_sec_valid(sec_v), .o_sec_data(sec_d), .o_byte_valid(bval),
    .o_byte(bdat));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    return c;
  endfunction
  // Program bytes count up, so a word assembled in the wrong byte order is caught.
  always @(posedge i_clk) begin
    if (ram.valid === 1'b1) begin
      chk(ram.data, 32'h07060504 + 32'h04040404 * nwr);
      chk(ram.addr, 16'(nwr));
      nwr++;
    end
  end
  task automatic boot(input logic [1:0] st, input logic sb, input int w, input int md);
    logic [31:0] c;
    logic [31:0] t;
    int k;
    c = 32'hffffffff;
    nwr = 0;
    bil_boot_mem_i.sec = sb ? 32'h00000020 : 32'hffffffdf;
    bil_boot_mem_i.n = 4 * w + 8;
    for (k = 0; k < 4 * w + 4; k++) begin
      bil_boot_mem_i.img[k] = k < 4 ? 8'(w >> (8 * k)) : 8'(k);
      c = crc8(c, bil_boot_mem_i.img[k]);
    end
    t = md == 0 ? 32'h0d15ab1e : ~c ^ (md == 2 ? 32'h1 : 32'h0);
    for (k = 0; k < 4; k++) bil_boot_mem_i.img[4 * w + 4 + k] = t[8 * k +: 8];
    @(posedge i_clk);
    {s1, s0} <= st;
    i_rst_b <= 1'b0;
    // The tile-2 boot straps live outside this block; the held reset stands for them.
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    chk(pd, 32'hffffffff);
    chk(run, 1'b0);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    k = 0;
    while (run !== 1'b1 && berr !== 1'b1 && k < 2000) begin
      @(negedge i_clk);
      k++;
    end
    chk(k < 2000, 1'b1);
    chk(pd, 32'h0);
    chk(otp, sb);
    chk(run, md != 2);
    chk(berr, md == 2);
    chk(skip, md == 0);
    chk(start, 16'h0000);
    chk(nwr, w);
    t[11:0] = st == 0 ? 12'h09f : st == 3 ? 12'h03f : st == 2 ? 12'h01f : 12'h00f;
    chk(cfg, {6'h00, t[11:0], 3'h1});
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    {i_rst_b, s0, s1, pll_wr, slow} = 5'h0;
    wdata = '0;
    boot(2'h0, 1'b1, 3, 0);
    boot(2'h3, 1'b0, 5, 1);
    slow <= 1'b1;
    boot(2'h2, 1'b0, 2, 2);
    boot(2'h1, 1'b1, 0, 1);
    @(posedge i_clk);
    pll_wr <= 1'b1;
    wdata <= {6'h3f, 12'hfff, 3'h7};
    @(posedge i_clk);
    pll_wr <= 1'b0;
    @(negedge i_clk);
    chk(cfg, {6'h3f, 12'hfff, 3'h7});
    end_of_test();
  end
endmodule

//--- verification/bil_boot_image_loader_checker.sv
// Concurrent checks on the ports of the boot image loader.
`timescale 1ns/10ps
module bil_boot_image_loader_checker #(
  parameter int DELAY_CYC = 10,
  parameter int ADDR_W = 16,
  parameter int GPIO_W = 32
) (
  // Clock, reset and straps
  input logic i_clk,
  input logic i_rst_b,
  input logic i_pll_strap_bit0,
  input logic i_pll_strap_bit1,
  // Boot source
  input logic o_sec_rd,
  input logic i_sec_valid,
  input logic [31:0] i_sec_data,
  input logic o_src_otp,
  input logic o_src_req,
  input logic [ADDR_W-1:0] o_src_addr,
  // PLL, RAM and status
  input logic i_pll_wr,
  input bil_pkg::bil_pll_cfg_t i_pll_wdata,
  input bil_pkg::bil_pll_cfg_t o_pll_cfg,
  input bil_pkg::bil_ram_wr_t o_ram_wr,
  input logic [GPIO_W-1:0] o_gpio_pulldown,
  input logic o_run,
  input logic [ADDR_W-1:0] o_start_addr,
  input logic o_boot_error,
  input logic o_crc_skipped
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  int cnt;
  logic sec5;
  function automatic logic [11:0] fb_of(logic [1:0] s);
    return s == 2'h0 ? 12'h09f : s == 2'h3 ? 12'h03f : s == 2'h2 ? 12'h01f : 12'h00f;
  endfunction
  // The wait is counted from the edge that takes the security word.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) cnt <= 0;
    else if (o_sec_rd && i_sec_valid) cnt <= 1;
    else if (cnt != 0 && !o_src_req) cnt <= cnt + 1;
  end
  always_ff @(posedge i_clk) begin
    if (o_sec_rd && i_sec_valid) sec5 <= i_sec_data[5];
  end
  sequence cfg_write;
    o_run && i_pll_wr;
  endsequence
  pulldown_in_reset_a: assert property (disable iff (1'b0) !i_rst_b |=> &o_gpio_pulldown)
    else $error("pull-downs off in reset");
  boot_delay_a: assert property ($rose(o_src_req) |-> cnt >= DELAY_CYC && cnt <= 10 * DELAY_CYC)
    else $error("boot delay out of range");
  boot_source_a: assert property ($rose(o_src_req) |-> o_src_otp == sec5)
    else $error("wrong boot source");
  strap_pll_a: assert property ($rose(o_src_req) |->
    o_pll_cfg == {6'h00, fb_of({i_pll_strap_bit1, i_pll_strap_bit0}), 3'h1})
    else $error("strap PLL setting wrong");
  sec_first_a: assert property (o_src_req |-> cnt != 0)
    else $error("boot source read before security word");
  ram_write_pulse_a: assert property (o_ram_wr.valid |-> !o_run ##1 !o_ram_wr.valid)
    else $error("RAM write not a load pulse");
  start_at_zero_a: assert property ($rose(o_run) |-> o_start_addr == 0 && o_src_addr == 0)
    else $error("start address not zero");
  error_holds_a: assert property (o_boot_error |=> o_boot_error && !o_run)
    else $error("boot error not held");
  skip_runs_a: assert property ($rose(o_crc_skipped) |-> o_run)
    else $error("skip without start");
  pll_write_a: assert property (cfg_write |=> o_pll_cfg == $past(i_pll_wdata))
    else $error("PLL write lost");
endmodule
bind bil_boot_image_loader bil_boot_image_loader_checker #(.DELAY_CYC(DELAY_CYC),
  .ADDR_W(ADDR_W), .GPIO_W(GPIO_W)) bil_boot_image_loader_checker_i (.i_clk, .i_rst_b,
  .i_pll_strap_bit0, .i_pll_strap_bit1, .o_sec_rd, .i_sec_valid, .i_sec_data, .o_src_otp,
  .o_src_req, .o_src_addr, .i_pll_wr, .i_pll_wdata, .o_pll_cfg, .o_ram_wr, .o_gpio_pulldown,
  .o_run, .o_start_addr, .o_boot_error, .o_crc_skipped);

//--- verification/bil_boot_mem.sv
// Behavioural boot memory: security word and boot byte stream.
`timescale 1ns/10ps
module bil_boot_mem (
  // Clock and pacing
  input wire logic i_clk,
  input wire logic i_slow,
  // Loader side
  input wire logic i_sec_rd,
  input wire logic i_src_req,
  output logic o_sec_valid,
  output logic [31:0] o_sec_data,
  output logic o_byte_valid,
  output logic [7:0] o_byte
);
  logic [7:0] img [0:63];
  logic [31:0] sec;
  int n;
  int pos;
  logic tick;
  initial begin
    o_sec_valid = 1'b0;
    o_sec_data = 32'h0;
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
    pos = 0;
    tick = 1'b0;
  end
  // Idle data lines toggle so that a loader sampling them outside a valid cycle is caught.
  always @(posedge i_clk) begin
    o_sec_valid <= i_sec_rd && !o_sec_valid;
    o_sec_data <= (i_sec_rd && !o_sec_valid) ? sec : ~o_sec_data;
  end
  always @(posedge i_clk) begin
    tick <= i_slow ? !tick : 1'b1;
    if (!i_src_req) pos <= 0;
    if (i_src_req && pos < n && tick) begin
      o_byte_valid <= 1'b1;
      o_byte <= img[pos];
      pos <= pos + 1;
    end else begin
      o_byte_valid <= 1'b0;
      o_byte <= ~o_byte;
    end
  end
endmodule
